// File: bench/rpf_read_master.sv
// Purpose: Memory read master on the far side of the filter.
// Assumes: Reads are one-cycle offers on the filter's clock.
// Notes:   Idle lines carry inverted values so stale data is never seen.
`timescale 1ns/1ps
`default_nettype none
module rpf_read_master (
  input  wire logic    clk_in,    // Clock.
  output logic         valid_out, // Read offered.
  output logic [63:0]  addr_out,  // Read address.
  output logic         dac_out    // Wide address.
);
  // Quiet lines at time zero.
  initial begin
    valid_out = 1'b0;
    addr_out  = 64'h0;
    dac_out   = 1'b0;
  end
  // Waits gap cycles, offers one read; a narrow read has junk above bit 31.
  task automatic offer(input logic [63:0] a, input logic dac, input int gap);
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    valid_out <= 1'b1;
    addr_out  <= dac ? a : {~a[31:0], a[31:0]};
    dac_out   <= dac;
    @(posedge clk_in);
    valid_out <= 1'b0;
    addr_out  <= ~addr_out;
    dac_out   <= ~dac_out;
  endtask
endmodule
`default_nettype wire

// File: bench/rpf_tb_top.sv
// Purpose: Self-checking bench of the read prefetch range filter.
// Assumes: APB answers are awaited under a bounded count.
// Notes:   Expected verdicts come from a shadow of the window registers.
`timescale 1ns/1ps
`default_nettype none
module rpf_tb_top;
  import rpf_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, e, d;
  logic rd_valid, rd_dac, q_valid, q_permit, q_grant;
  logic [AW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata, q;
  logic [3:0]    pstrb;
  logic [63:0]   rd_addr, b, s;
  logic [MW-1:0] q_mode, mode;
  logic [DW-1:0] sh [0:6];
  logic [DW-1:0] msk [0:6];
  logic [AW-1:0] ofs [0:6];
  int            num_errors, cmp_count;
  int            n_grant, n_deny;
  integer        seed;
  rpf_top i_rpf_top (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PSTRB_IN(pstrb), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .RD_VALID_IN(rd_valid), .RD_ADDR_IN(rd_addr), .RD_DAC_IN(rd_dac),
    .QUAL_VALID_OUT(q_valid), .QUAL_PERMIT_OUT(q_permit), .QUAL_GRANT_OUT(q_grant),
    .QUAL_MODE_OUT(q_mode));
  rpf_read_master i_rpf_read_master (.clk_in(clk), .valid_out(rd_valid),
    .addr_out(rd_addr), .dac_out(rd_dac));
  // 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------
  // Compare, report and bus tasks
  // ----------------------------------------
  task automatic cmp_word(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One APB transfer; the answer is taken at the edge that sees pready.
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t bus answer timed out", $time);
      results();
    end
  endtask
  // Expected window verdict from the register shadow.
  function automatic logic exp_permit(input logic [63:0] x);
    logic [64:0] b1, b2, xa;
    logic        h1, h2, i1, i2, n1, n2;
    xa = {1'b0, x};
    b1 = {1'b0, sh[1], sh[0]};
    b2 = {1'b0, sh[4], sh[3]};
    n1 = sh[2][31:1] != 0;
    n2 = sh[5] != 0;
    h1 = n1 && xa >= b1 && xa < b1 + {sh[2][31:1], 1'b0};
    h2 = n2 && xa >= b2 && xa < b2 + sh[5];
    i1 = sh[2][0];
    i2 = sh[6][0] ? i1 : sh[6][1];
    return !(h1 && !i1 || h2 && !i2) && (!(n1 && i1 || n2 && i2) || h1 && i1 || h2 && i2);
  endfunction
  // Offers a read and checks its verdict one cycle later.
  task automatic chk_rd(input logic [63:0] a, input logic dac);
    logic [63:0] x;
    x = dac ? a : {32'h0, a[31:0]};
    i_rpf_read_master.offer(a, dac, $unsigned($random(seed)) % 3);
    #1;
    cmp_flag(q_valid, 1'b1);
    cmp_flag(q_permit, exp_permit(x));
    cmp_flag(q_grant, exp_permit(x) && mode != 0);
    if (exp_permit(x) && mode != 0) begin
      n_grant++;
    end else begin
      n_deny++;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    num_errors = 0;
    cmp_count = 0;
    n_grant = 0;
    n_deny = 0;
    seed = 32'hef40;
    mode = '0;
    ofs = '{OFS_W1_BLO, OFS_W1_BHI, OFS_W1_SZC, OFS_W2_BLO, OFS_W2_BHI, OFS_W2_SZ, OFS_CFG};
    msk = '{32'hffff_ffff, 32'h1, 32'h1fff, 32'hffff_ffff, 32'h1, 32'h1fff, 32'h3};
    sh = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, then an unmapped hole.
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ofs[i], '0);
      cmp_word(q, sh[i]);
    end
    apb(1'b0, 12'h04c, '0);
    cmp_flag(e, 1'b1);
    chk_rd(64'h1234_5678_9abc_def0, 1'b1);
    $display("test reset values done");
    // every mode code with the windows still empty.
    for (int m = 0; m < 16; m++) begin
      apb(1'b1, OFS_MODE, 32'(m) << MODE_LSB);
      mode = m[3:0];
      apb(1'b0, OFS_MODE, '0);
      cmp_word(q, 32'(m) << MODE_LSB);
      cmp_word(32'(q_mode), 32'(m));
      chk_rd({$random(seed), $random(seed)}, 1'b1);
    end
    $display("test mode codes done");
    // random windows probed at and around both edges.
    for (int k = 0; k < 50; k++) begin
      for (int i = 0; i < 7; i++) begin
        apb(1'b1, ofs[i], $random(seed) & msk[i]);
        sh[i] = pwdata;
        apb(1'b0, ofs[i], '0);
        cmp_word(q, sh[i]);
      end
      for (int j = 0; j < 8; j++) begin
        b = j[0] ? {sh[4], sh[3]} : {sh[1], sh[0]};
        s = j[0] ? 64'(sh[5]) : 64'({sh[2][31:1], 1'b0});
        d = 1'($random(seed));
        chk_rd(b + (j[2] ? s : 64'h0) - (j[1] ? 64'h1 : 64'h0), d);
      end
    end
    $display("test random windows done");
    // Granted and refused counters against the verdicts seen since reset.
    apb(1'b0, OFS_GCNT, '0);
    cmp_word(q, 32'(n_grant));
    apb(1'b0, OFS_DCNT, '0);
    cmp_word(q, 32'(n_deny));
    // A write with only byte lane 1 enabled leaves the other bytes alone.
    pstrb <= 4'h2;
    apb(1'b1, OFS_W1_BLO, 32'hffff_ffff);
    pstrb <= 4'hf;
    apb(1'b0, OFS_W1_BLO, '0);
    cmp_word(q, (sh[0] & 32'hffff_00ff) | 32'h0000_ff00);
    $display("test counters and strobes done");
    results();
  end
endmodule
`default_nettype wire

// File: bench/rpf_top_asserts.sv
// Purpose: Port-level checks of the read prefetch range filter.
// Assumes: Only the top module's ports are visible.
// Notes:   The mode field is shadowed from APB writes.
`timescale 1ns/1ps
`default_nettype none
module rpf_top_asserts
  import rpf_pkg::*;
(
  input wire logic          REF_CLK_IN,      // Clock.
  input wire logic          RESET_N_IN,      // Reset, low.
  input wire logic          PSEL_IN,         // Select.
  input wire logic          PENABLE_IN,      // Enable.
  input wire logic          PWRITE_IN,       // Write.
  input wire logic [AW-1:0] PADDR_IN,        // Address.
  input wire logic [DW-1:0] PWDATA_IN,       // Write data.
  input wire logic [3:0]    PSTRB_IN,        // Strobes.
  input wire logic          PSLVERR_OUT,     // Error.
  input wire logic          RD_VALID_IN,     // Read offered.
  input wire logic          QUAL_VALID_OUT,  // Verdict.
  input wire logic          QUAL_PERMIT_OUT, // Permit.
  input wire logic          QUAL_GRANT_OUT,  // Grant.
  input wire logic [MW-1:0] QUAL_MODE_OUT    // Mode copy.
);
  logic          wr_acc;
  logic          mode_wr;
  logic          win_acc;
  logic [MW-1:0] mode_ff;
  logic          touched_ff;
  // Decode accesses to the mode field and to the window registers.
  assign wr_acc  = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign mode_wr = wr_acc && PADDR_IN == OFS_MODE && PSTRB_IN[0];
  assign win_acc = PSEL_IN && PENABLE_IN && PADDR_IN >= OFS_W1_BLO && PADDR_IN <= OFS_W2_SZ;
  // Mode shadow and a flag that any window register was written.
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      mode_ff    <= '0;
      touched_ff <= 1'b0;
    end else begin
      if (mode_wr) mode_ff <= PWDATA_IN[MODE_LSB +: MW];
      if (win_acc && PWRITE_IN) touched_ff <= 1'b1;
    end
  end
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  sequence s_rd_taken;
    RD_VALID_IN;
  endsequence
  sequence s_mode_quiet;
    !mode_wr [*2];
  endsequence
  AST_VERDICT_LATE: assert property (s_rd_taken |=> QUAL_VALID_OUT)
    else $error("verdict missing one cycle after a read");
  AST_VERDICT_CAUSE: assert property (QUAL_VALID_OUT |-> $past(RD_VALID_IN))
    else $error("verdict without a read");
  AST_IDLE_QUIET: assert property (!QUAL_VALID_OUT |-> !QUAL_PERMIT_OUT && !QUAL_GRANT_OUT)
    else $error("permit or grant outside a verdict");
  AST_GRANT_PERMIT: assert property (QUAL_GRANT_OUT |-> QUAL_PERMIT_OUT)
    else $error("grant without permit");
  AST_GRANT_MODE: assert property (QUAL_VALID_OUT |->
    QUAL_GRANT_OUT == (QUAL_PERMIT_OUT && $past(mode_ff) != 0))
    else $error("grant disagrees with mode field");
  AST_MODE_COPY: assert property (s_mode_quiet |-> QUAL_MODE_OUT == mode_ff)
    else $error("mode copy differs from last write");
  AST_RESET_OPEN: assert property (QUAL_VALID_OUT && !touched_ff |-> QUAL_PERMIT_OUT)
    else $error("empty windows refused a read");
  AST_WIN_MAPPED: assert property (win_acc |-> !PSLVERR_OUT)
    else $error("window register reported as unmapped");
endmodule
bind rpf_top rpf_top_asserts i_rpf_top_asserts (
  .REF_CLK_IN(REF_CLK_IN), .RESET_N_IN(RESET_N_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN), .PSLVERR_OUT(PSLVERR_OUT),
  .RD_VALID_IN(RD_VALID_IN), .QUAL_VALID_OUT(QUAL_VALID_OUT),
  .QUAL_PERMIT_OUT(QUAL_PERMIT_OUT), .QUAL_GRANT_OUT(QUAL_GRANT_OUT),
  .QUAL_MODE_OUT(QUAL_MODE_OUT));
`default_nettype wire

// File: hw/rpf_pkg.sv
// Purpose: Shared constants for the read prefetch range filter.
// Assumes: APB register map with 32-bit aligned words.
// Notes:   Offsets are byte addresses on the register bus.
package rpf_pkg;
  localparam int AW = 12;
  localparam int DW = 32;
  localparam int MW = 4;
  // Register byte offsets.
  localparam logic [AW-1:0] OFS_MODE   = 12'h0040;
  localparam logic [AW-1:0] OFS_W1_BLO = 12'h0050;
  localparam logic [AW-1:0] OFS_W1_BHI = 12'h0054;
  localparam logic [AW-1:0] OFS_W1_SZC = 12'h0058;
  localparam logic [AW-1:0] OFS_W2_BLO = 12'h005C;
  localparam logic [AW-1:0] OFS_W2_BHI = 12'h0060;
  localparam logic [AW-1:0] OFS_W2_SZ  = 12'h0064;
  localparam logic [AW-1:0] OFS_CFG    = 12'h0070;
  localparam logic [AW-1:0] OFS_STAT   = 12'h0074;
  localparam logic [AW-1:0] OFS_GCNT   = 12'h0078;
  localparam logic [AW-1:0] OFS_DCNT   = 12'h007C;
  // Field positions.
  localparam int MODE_LSB  = 4;
  localparam int W1_POL    = 0;
  localparam int CFG_FOLW  = 0;
  localparam int CFG_W2POL = 1;
  localparam int ST_PERMIT = 0;
  localparam int ST_HIT1   = 1;
  localparam int ST_HIT2   = 2;
  localparam int ST_GRANT  = 3;
  // Reset values.
  localparam logic [DW-1:0] RST_ZERO = 32'h0000_0000;
  localparam logic [MW-1:0] RST_MODE = 4'h0;
  localparam logic [1:0]    RST_CFG  = 2'h1;
endpackage

// File: hw/rpf_read_qualifier.sv
// Purpose: Combines window hits and polarities into one registered verdict.
// Assumes: Hits belong to the address presented with rd_valid_in.
// Notes:   The verdict appears one clock after the read is offered.
`timescale 1ns/1ps
`default_nettype none
module rpf_read_qualifier
  import rpf_pkg::*;
(
  input  wire logic          clk_in,     // Clock.
  input  wire logic          rst_n_in,   // Asynchronous reset, low.
  input  wire logic          rd_valid_in,// Read offered.
  input  wire logic          hit1_in,    // Inside window 1.
  input  wire logic          hit2_in,    // Inside window 2.
  input  wire logic          inc1_in,    // Window 1 includes.
  input  wire logic          inc2_in,    // Window 2 includes.
  input  wire logic          act1_in,    // Window 1 not empty.
  input  wire logic          act2_in,    // Window 2 not empty.
  input  wire logic [MW-1:0] mode_in,    // Enhanced read mode field.
  output logic               valid_out,  // Verdict valid pulse.
  output logic               permit_out, // Windows allow the mode.
  output logic               grant_out   // Mode actually granted.
);
  logic excl_w;
  logic need_w;
  logic incl_w;
  logic permit_w;
  // An exclude hit forbids; include windows, if any, must be hit.
  assign excl_w   = (hit1_in && !inc1_in) || (hit2_in && !inc2_in);
  assign need_w   = (act1_in && inc1_in) || (act2_in && inc2_in);
  assign incl_w   = (hit1_in && inc1_in) || (hit2_in && inc2_in);
  assign permit_w = !excl_w && (!need_w || incl_w);
  // Register the verdict; the grant needs the window permit and a nonzero mode field.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      valid_out  <= 1'b0;
      permit_out <= 1'b0;
      grant_out  <= 1'b0;
    end else begin
      valid_out  <= rd_valid_in;
      permit_out <= rd_valid_in && permit_w;
      grant_out  <= rd_valid_in && permit_w && (mode_in != RST_MODE);
    end
  end
endmodule
`default_nettype wire

// File: hw/rpf_top.sv
// Purpose: Read prefetch range filter with its APB register file.
// Assumes: Reads come from logic on the same clock; no synchroniser.
// Notes:   APB answers in the first access cycle with no wait state.
//
// Operation
// R01: Window 1 is built from low base, upper base and size registers.
// R02: Window 1 base bits 63..32 come from their own full register.
// R03: Window 1 size is bits 31..1 of its range register, 2-byte steps.
// R04: Range bit 0 low forbids the enhanced mode for reads inside window 1.
// R05: Range bit 0 high allows the enhanced mode only inside window 1.
// R06: The 4-bit mode field grants the mode; windows only restrict it.
// R07: Window 2 has its own low base and size registers.
// R08: Window 2 base bits 63..32 come from their own full register.
// R09: Window 2 size is all 32 bits of its size register.
// R10: Reset clears all bases, sizes and the window 1 polarity bit.
// R11: Inside means base <= address < base+size; 32-bit addresses zero-extend.
// R12: Window 2 follows window 1 polarity by default, configurable.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rpf_top
  import rpf_pkg::*;
(
  input  wire logic          REF_CLK_IN,      // Clock, 40 MHz.
  input  wire logic          RESET_N_IN,      // Asynchronous reset, low.
  input  wire logic          PSEL_IN,         // APB select.
  input  wire logic          PENABLE_IN,      // APB enable.
  input  wire logic          PWRITE_IN,       // APB write.
  input  wire logic [AW-1:0] PADDR_IN,        // APB byte address.
  input  wire logic [DW-1:0] PWDATA_IN,       // APB write data.
  input  wire logic [3:0]    PSTRB_IN,        // APB byte strobes.
  output logic      [DW-1:0] PRDATA_OUT,      // APB read data.
  output logic               PREADY_OUT,      // APB ready.
  output logic               PSLVERR_OUT,     // APB error.
  input  wire logic          RD_VALID_IN,     // Memory read offered.
  input  wire logic [63:0]   RD_ADDR_IN,      // Read address.
  input  wire logic          RD_DAC_IN,       // Address is 64-bit.
  output logic               QUAL_VALID_OUT,  // Verdict pulse.
  output logic               QUAL_PERMIT_OUT, // Windows permit.
  output logic               QUAL_GRANT_OUT,  // Enhanced read granted.
  output logic      [MW-1:0] QUAL_MODE_OUT    // Mode field copy.
);

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------

  // Merges write data into a register under byte strobes.
  function automatic logic [DW-1:0] merge_bytes(
    input logic [DW-1:0] old_val,
    input logic [DW-1:0] new_val,
    input logic [3:0]    strb
  );
    logic [DW-1:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Counts up and holds at the top.
  function automatic logic [DW-1:0] sat_inc(input logic [DW-1:0] val);
    logic [DW-1:0] res;
    res = val;
    if (val != 32'hFFFF_FFFF) begin
      res = val + 32'h0000_0001;
    end
    return res;
  endfunction

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------

  logic [DW-1:0] w1_base_lo_ff;
  logic [DW-1:0] w1_base_hi_ff;
  logic [DW-1:0] w1_size_ctrl_ff;
  logic [DW-1:0] w2_base_lo_ff;
  logic [DW-1:0] w2_base_hi_ff;
  logic [DW-1:0] w2_size_ff;
  logic [MW-1:0] mode_ff;
  logic [1:0]    cfg_ff;
  logic [3:0]    stat_ff;
  logic [DW-1:0] gcnt_ff;
  logic [DW-1:0] dcnt_ff;
  logic [DW-1:0] prdata_ff;
  logic          pslverr_ff;

  logic [DW-1:0] nxt_prdata;
  logic          nxt_pslverr;
  logic [DW-1:0] nxt_gcnt;
  logic [DW-1:0] nxt_dcnt;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------

  logic setup_w;
  logic wr_w;
  logic sel_mode_w;
  logic sel_w1lo_w;
  logic sel_w1hi_w;
  logic sel_w1sz_w;
  logic sel_w2lo_w;
  logic sel_w2hi_w;
  logic sel_w2sz_w;
  logic sel_cfg_w;
  logic sel_stat_w;
  logic sel_gcnt_w;
  logic sel_dcnt_w;
  logic hit_any_w;

  // Setup cycle prepares the answer; writes land in the access cycle.
  assign setup_w    = PSEL_IN && !PENABLE_IN;
  assign wr_w       = PSEL_IN && PENABLE_IN && PWRITE_IN && !pslverr_ff;
  assign sel_mode_w = (PADDR_IN == OFS_MODE);
  assign sel_w1lo_w = (PADDR_IN == OFS_W1_BLO);
  assign sel_w1hi_w = (PADDR_IN == OFS_W1_BHI);
  assign sel_w1sz_w = (PADDR_IN == OFS_W1_SZC);
  assign sel_w2lo_w = (PADDR_IN == OFS_W2_BLO);
  assign sel_w2hi_w = (PADDR_IN == OFS_W2_BHI);
  assign sel_w2sz_w = (PADDR_IN == OFS_W2_SZ);
  assign sel_cfg_w  = (PADDR_IN == OFS_CFG);
  assign sel_stat_w = (PADDR_IN == OFS_STAT);
  assign sel_gcnt_w = (PADDR_IN == OFS_GCNT);
  assign sel_dcnt_w = (PADDR_IN == OFS_DCNT);
  assign hit_any_w  = sel_mode_w || sel_w1lo_w || sel_w1hi_w || sel_w1sz_w
                   || sel_w2lo_w || sel_w2hi_w || sel_w2sz_w || sel_cfg_w
                   || sel_stat_w || sel_gcnt_w || sel_dcnt_w;

  // Read multiplexer; unmapped addresses read zero and flag an error.
  always_comb begin
    nxt_prdata = RST_ZERO;
    if (sel_mode_w) begin
      nxt_prdata[MODE_LSB +: MW] = mode_ff;
    end else if (sel_w1lo_w) begin
      nxt_prdata = w1_base_lo_ff;
    end else if (sel_w1hi_w) begin
      nxt_prdata = w1_base_hi_ff;
    end else if (sel_w1sz_w) begin
      nxt_prdata = w1_size_ctrl_ff;
    end else if (sel_w2lo_w) begin
      nxt_prdata = w2_base_lo_ff;
    end else if (sel_w2hi_w) begin
      nxt_prdata = w2_base_hi_ff;
    end else if (sel_w2sz_w) begin
      nxt_prdata = w2_size_ff;
    end else if (sel_cfg_w) begin
      nxt_prdata[1:0] = cfg_ff;
    end else if (sel_stat_w) begin
      nxt_prdata[3:0] = stat_ff;
    end else if (sel_gcnt_w) begin
      nxt_prdata = gcnt_ff;
    end else if (sel_dcnt_w) begin
      nxt_prdata = dcnt_ff;
    end
  end

  assign nxt_pslverr = !hit_any_w;

  // Answer registers, loaded during the setup cycle.
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      prdata_ff  <= RST_ZERO;
      pslverr_ff <= 1'b0;
    end else if (setup_w) begin
      prdata_ff  <= PWRITE_IN ? RST_ZERO : nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign PRDATA_OUT  = prdata_ff;
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && pslverr_ff;

  // ------------------------------------------------------------
  // Window registers
  // ------------------------------------------------------------

  // R10 reset clears
  // Window bases and sizes start at zero, so no window matches.
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      w1_base_lo_ff   <= RST_ZERO;
      w1_base_hi_ff   <= RST_ZERO;
      w1_size_ctrl_ff <= RST_ZERO;
      w2_base_lo_ff   <= RST_ZERO;
      w2_base_hi_ff   <= RST_ZERO;
      w2_size_ff      <= RST_ZERO;
    end else if (wr_w) begin
      if (sel_w1lo_w) begin
        w1_base_lo_ff <= merge_bytes(w1_base_lo_ff, PWDATA_IN, PSTRB_IN);
      end
      if (sel_w1hi_w) begin
        w1_base_hi_ff <= merge_bytes(w1_base_hi_ff, PWDATA_IN, PSTRB_IN);
      end
      if (sel_w1sz_w) begin
        w1_size_ctrl_ff <= merge_bytes(w1_size_ctrl_ff, PWDATA_IN, PSTRB_IN);
      end
      if (sel_w2lo_w) begin
        w2_base_lo_ff <= merge_bytes(w2_base_lo_ff, PWDATA_IN, PSTRB_IN);
      end
      if (sel_w2hi_w) begin
        w2_base_hi_ff <= merge_bytes(w2_base_hi_ff, PWDATA_IN, PSTRB_IN);
      end
      if (sel_w2sz_w) begin
        w2_size_ff <= merge_bytes(w2_size_ff, PWDATA_IN, PSTRB_IN);
      end
    end
  end

  // Mode field and window 2 polarity control, low byte only.
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      mode_ff <= RST_MODE;
      cfg_ff  <= RST_CFG;
    end else if (wr_w && PSTRB_IN[0]) begin
      if (sel_mode_w) begin
        mode_ff <= PWDATA_IN[MODE_LSB +: MW];
      end
      if (sel_cfg_w) begin
        cfg_ff <= PWDATA_IN[1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Window formation and matching
  // ------------------------------------------------------------

  rpf_win_if win1_if ();
  rpf_win_if win2_if ();

  logic [63:0] rd_addr_w;
  logic        inc1_w;
  logic        inc2_w;

  // R11 zero extension
  // A single-address read carries only 32 bits; the top half is zero.
  assign rd_addr_w = RD_DAC_IN ? RD_ADDR_IN : {32'h0000_0000, RD_ADDR_IN[31:0]};

  // R01 window 1 base
  // R02 upper base bits
  assign win1_if.base = {w1_base_hi_ff, w1_base_lo_ff};
  // R03 size bits 31..1
  assign win1_if.size = {w1_size_ctrl_ff[31:1], 1'b0};
  assign win1_if.addr = rd_addr_w;

  // R07 window 2 base
  // R08 upper base bits
  assign win2_if.base = {w2_base_hi_ff, w2_base_lo_ff};
  // R09 full size register
  assign win2_if.size = w2_size_ff;
  assign win2_if.addr = rd_addr_w;

  // R04 R05 polarity bit
  assign inc1_w = w1_size_ctrl_ff[W1_POL];
  // R12 window 2 polarity
  assign inc2_w = cfg_ff[CFG_FOLW] ? inc1_w : cfg_ff[CFG_W2POL];

  // R11 range compare
  rpf_window_match u_match1 (
    .win (win1_if.matcher)
  );

  rpf_window_match u_match2 (
    .win (win2_if.matcher)
  );

  // ------------------------------------------------------------
  // Verdict
  // ------------------------------------------------------------

  logic qual_valid_w;
  logic qual_permit_w;
  logic qual_grant_w;

  // R04 R05 R06 combined verdict
  rpf_read_qualifier u_qual (
    .clk_in      (REF_CLK_IN),
    .rst_n_in    (RESET_N_IN),
    .rd_valid_in (RD_VALID_IN),
    .hit1_in     (win1_if.hit),
    .hit2_in     (win2_if.hit),
    .inc1_in     (inc1_w),
    .inc2_in     (inc2_w),
    .act1_in     (win1_if.size != RST_ZERO),
    .act2_in     (win2_if.size != RST_ZERO),
    .mode_in     (mode_ff),
    .valid_out   (qual_valid_w),
    .permit_out  (qual_permit_w),
    .grant_out   (qual_grant_w)
  );

  assign QUAL_VALID_OUT  = qual_valid_w;
  assign QUAL_PERMIT_OUT = qual_permit_w;
  assign QUAL_GRANT_OUT  = qual_grant_w;
  assign QUAL_MODE_OUT   = mode_ff;

  // ------------------------------------------------------------
  // Status and counters
  // ------------------------------------------------------------

  // Remembers the outcome of the latest offered read.
  // A verdict landing with a new offer wins over the clear, so back-to-back reads keep it.
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      stat_ff <= 4'h0;
    end else begin
      if (RD_VALID_IN) begin
        stat_ff[ST_HIT1] <= win1_if.hit;
        stat_ff[ST_HIT2] <= win2_if.hit;
      end
      if (qual_valid_w) begin
        stat_ff[ST_PERMIT] <= qual_permit_w;
        stat_ff[ST_GRANT]  <= qual_grant_w;
      end else if (RD_VALID_IN) begin
        stat_ff[ST_PERMIT] <= 1'b0;
        stat_ff[ST_GRANT]  <= 1'b0;
      end
    end
  end

  // A write clears a counter; a count in the same cycle is added after the clear.
  always_comb begin
    nxt_gcnt = gcnt_ff;
    nxt_dcnt = dcnt_ff;
    if (wr_w && sel_gcnt_w) begin
      nxt_gcnt = RST_ZERO;
    end
    if (wr_w && sel_dcnt_w) begin
      nxt_dcnt = RST_ZERO;
    end
    if (qual_valid_w && qual_grant_w) begin
      nxt_gcnt = sat_inc(nxt_gcnt);
    end
    if (qual_valid_w && !qual_grant_w) begin
      nxt_dcnt = sat_inc(nxt_dcnt);
    end
  end

  // Granted and refused read counters.
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      gcnt_ff <= RST_ZERO;
      dcnt_ff <= RST_ZERO;
    end else begin
      gcnt_ff <= nxt_gcnt;
      dcnt_ff <= nxt_dcnt;
    end
  end

endmodule
`default_nettype wire

// File: hw/rpf_win_if.sv
// Purpose: Carrier between the filter core and one window comparator.
// Assumes: One instance per address window.
// Notes:   Base is 64 bits, size 32 bits, address already widened.
`timescale 1ns/1ps
`default_nettype none
interface rpf_win_if;
  logic [63:0] base;
  logic [31:0] size;
  logic [63:0] addr;
  logic        hit;
  modport owner (output base, size, addr, input hit);
  modport matcher (input base, size, addr, output hit);
endinterface
`default_nettype wire

// File: hw/rpf_window_match.sv
// Purpose: Decides whether an address lies inside one window.
// Assumes: Base and size are stable register values.
// Notes:   Comparison uses 65 bits so base plus size cannot wrap.
`timescale 1ns/1ps
`default_nettype none
module rpf_window_match (
  rpf_win_if.matcher win  // Window and address under test.
);
  logic [64:0] lim_w;
  logic        nonzero_w;
  logic        above_w;
  logic        below_w;
  // The upper limit of the window, exclusive.
  assign lim_w     = {1'b0, win.base} + {33'h0_0000_0000, win.size};
  assign nonzero_w = (win.size != 32'h0000_0000);
  assign above_w   = (win.addr >= win.base);
  assign below_w   = ({1'b0, win.addr} < lim_w);
  // An empty window never matches.
  assign win.hit   = nonzero_w && above_w && below_w;
endmodule
`default_nettype wire
